// ---- design/eb_eeprom_slave.sv ----
`timescale 1ns/100ps
`include "eb_regs.svh"
// How it works
// - during the write cycle every command, own address included, gets no acknowledge
// - a new slave address is acknowledged only after programming has ended
// - the self-timed write cycle ends within 5 ms
// - start followed directly by stop aborts the command, nothing executes
// - an aborted read leaves the word address counter at the address it had reached
// - power-on reset puts the state machine into standby
// - low supply lockout blocks every write to the array
// - respond only when the three select bits match the select pins
// - last slave address bit: one reads, zero writes
// - the write cycle starts at the stop ending a byte or page write
// - write inhibit high blocks writes, low allows them
module eb_eeprom_slave #(
  parameter int unsigned WR_CYCLES = `EB_WR_CYCLES,
  parameter logic [3:0]  DEV_TYPE  = 4'h6  // arbitrary device type value
) (
  input  wire logic ref_clk_in,
  input  wire logic rst_n_in,
  input  wire logic link_clk_in,
  input  wire logic scl_in,
  input  wire logic sda_in,
  input  wire logic select_pin_0_in,
  input  wire logic select_pin_1_in,
  input  wire logic select_pin_2_in,
  input  wire logic write_inhibit_in,
  input  wire logic low_supply_write_lockout_in,
  output logic      sda_out,
  output logic      sda_oe_n_out,
  output logic      write_busy_out
);

  // --------------------------------------------------------------------------
  // link domain: bus sampling and event detection
  // --------------------------------------------------------------------------
  logic [2:0]      scl_sh_q;
  logic [2:0]      sda_sh_q;
  eb_pkg::eb_evt_t evt_tgl_q;
  logic            bit_q;
  logic [1:0]      oe_sync_q;
  logic            sda_zero_q;
  logic            scl_rise;
  logic            scl_fall;
  logic            bus_start;
  logic            bus_stop;

  always_ff @(posedge link_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      scl_sh_q <= 3'h7;
      sda_sh_q <= 3'h7;
    end else begin
      scl_sh_q <= {scl_sh_q[1:0], scl_in};
      sda_sh_q <= {sda_sh_q[1:0], sda_in};
    end
  end

  assign scl_rise  = scl_sh_q[1] & ~scl_sh_q[2];
  assign scl_fall  = ~scl_sh_q[1] & scl_sh_q[2];
  assign bus_start = scl_sh_q[1] & scl_sh_q[2] & ~sda_sh_q[1] & sda_sh_q[2];
  assign bus_stop  = scl_sh_q[1] & scl_sh_q[2] & sda_sh_q[1] & ~sda_sh_q[2];

  always_ff @(posedge link_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      evt_tgl_q <= '0;
      bit_q     <= 1'h1;
    end else begin
      if (scl_rise) begin
        evt_tgl_q.rise <= ~evt_tgl_q.rise;
        bit_q          <= sda_sh_q[1];
      end
      if (scl_fall) begin
        evt_tgl_q.fall <= ~evt_tgl_q.fall;
      end
      if (bus_start) begin
        evt_tgl_q.start <= ~evt_tgl_q.start;
      end
      if (bus_stop) begin
        evt_tgl_q.stop <= ~evt_tgl_q.stop;
      end
    end
  end

  // drive request from the engine, brought back to the pin
  logic drive_n_q;
  always_ff @(posedge link_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      oe_sync_q  <= 2'h3;
      sda_zero_q <= 1'h0;
    end else begin
      oe_sync_q  <= {oe_sync_q[0], drive_n_q};
      sda_zero_q <= 1'h0;
    end
  end

  assign sda_oe_n_out = oe_sync_q[1];
  assign sda_out      = sda_zero_q;
  // --------------------------------------------------------------------------
  // reference domain: synchronisers
  // --------------------------------------------------------------------------
  eb_pkg::eb_evt_t tgl_s1_q;
  eb_pkg::eb_evt_t tgl_s2_q;
  eb_pkg::eb_evt_t tgl_s3_q;
  eb_pkg::eb_evt_t ev;
  logic [1:0]      bit_s_q;
  logic [4:0]      pin_s1_q;
  logic [4:0]      pin_s2_q;
  logic            wp_s;
  logic            low_s;
  logic [2:0]      sel_s;

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tgl_s1_q <= '0;
      tgl_s2_q <= '0;
      tgl_s3_q <= '0;
      bit_s_q  <= 2'h3;
    end else begin
      tgl_s1_q <= evt_tgl_q;
      tgl_s2_q <= tgl_s1_q;
      tgl_s3_q <= tgl_s2_q;
      // data bit rides level with tgl_s2_q, so it is current when ev.rise fires
      bit_s_q  <= {bit_s_q[0], bit_q};
    end
  end
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_s1_q <= 5'h00;
      pin_s2_q <= 5'h00;
    end else begin
      pin_s1_q <= {low_supply_write_lockout_in, write_inhibit_in,
                   select_pin_2_in, select_pin_1_in, select_pin_0_in};
      pin_s2_q <= pin_s1_q;
    end
  end

  assign ev    = tgl_s2_q ^ tgl_s3_q;
  assign low_s = pin_s2_q[4];
  assign wp_s  = pin_s2_q[3];
  assign sel_s = pin_s2_q[2:0];

  // --------------------------------------------------------------------------
  // protocol engine
  // --------------------------------------------------------------------------
  logic [7:0]         mem [`EB_MEM_DEPTH];
  logic [7:0]         pg_buf_q [`EB_PAGE_BYTES];
  logic [7:0]         pg_valid_q;
  logic [3:0]         pg_page_q;
  logic [2:0]         pg_idx_q;
  eb_pkg::eb_state_t  state_q;
  eb_pkg::eb_phase_t  phase_q;
  logic [3:0]         cnt_q;
  logic [7:0]         shift_q;
  logic [6:0]         addr_q;
  logic               start_seen_q;
  logic               master_ack_q;
  logic               busy_q;
  logic               byte_done;
  logic               addr_match;
  logic               stop_commit;
  logic               commit_now;
  logic [7:0]         rd_byte;

  assign byte_done  = ev.fall && (cnt_q == `EB_BITS_PER_BYTE);
  assign rd_byte    = mem[addr_q];
  assign addr_match = (shift_q[`EB_SA_TYPE_MSB:`EB_SA_TYPE_LSB] == DEV_TYPE)
                   && (shift_q[`EB_SA_SEL_MSB:`EB_SA_SEL_LSB] == sel_s);
  // a start with no bit before the stop cancels instead of committing
  assign stop_commit = ev.stop && !start_seen_q
                    && (phase_q == eb_pkg::EB_PH_WDATA) && (|pg_valid_q)
                    && !wp_s
                    && !low_s
                    && !busy_q;

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q      <= eb_pkg::EB_IDLE;
      phase_q      <= eb_pkg::EB_PH_ADDR;
      cnt_q        <= 4'h0;
      shift_q      <= 8'h00;
      addr_q       <= 7'h00;
      drive_n_q    <= 1'h1;
      start_seen_q <= 1'h0;
      master_ack_q <= 1'h0;
      pg_valid_q   <= 8'h00;
      pg_page_q    <= 4'h0;
      pg_idx_q     <= 3'h0;
    end else if (ev.start) begin
      state_q      <= eb_pkg::EB_RX;
      phase_q      <= eb_pkg::EB_PH_ADDR;
      cnt_q        <= 4'h0;
      drive_n_q    <= 1'h1;
      start_seen_q <= 1'h1;
    end else if (ev.stop) begin
      // an aborted read keeps whatever address it had reached
      state_q      <= eb_pkg::EB_IDLE;
      phase_q      <= eb_pkg::EB_PH_ADDR;
      drive_n_q    <= 1'h1;
      start_seen_q <= 1'h0;
      if (!stop_commit && !busy_q) begin
        pg_valid_q <= 8'h00;
      end
    end else begin
      unique case (state_q)
        eb_pkg::EB_IDLE: begin
        end
        eb_pkg::EB_RX: begin
          if (ev.rise) begin
            shift_q      <= {shift_q[6:0], bit_s_q[1]};
            cnt_q        <= cnt_q + 4'h1;
            start_seen_q <= 1'h0;
          end else if (byte_done) begin
            cnt_q <= 4'h0;
            unique case (phase_q)
              eb_pkg::EB_PH_ADDR: begin
                if (addr_match && !busy_q) begin
                  drive_n_q <= 1'h0;
                  state_q   <= eb_pkg::EB_ACK;
                  phase_q   <= shift_q[`EB_SA_RW_BIT] ? eb_pkg::EB_PH_READ
                                                      : eb_pkg::EB_PH_WADDR;
                end else begin
                  state_q <= eb_pkg::EB_IDLE;
                end
              end
              eb_pkg::EB_PH_WADDR: begin
                addr_q     <= shift_q[6:0];
                pg_page_q  <= shift_q[6:3];
                pg_idx_q   <= shift_q[2:0];
                pg_valid_q <= 8'h00;
                phase_q    <= eb_pkg::EB_PH_WDATA;
                drive_n_q  <= 1'h0;
                state_q    <= eb_pkg::EB_ACK;
              end
              eb_pkg::EB_PH_WDATA: begin
                // page index wraps, later bytes overwrite earlier ones
                pg_valid_q[pg_idx_q] <= 1'h1;
                addr_q               <= {pg_page_q, pg_idx_q};
                pg_idx_q             <= pg_idx_q + 3'h1;
                drive_n_q            <= 1'h0;
                state_q              <= eb_pkg::EB_ACK;
              end
              default: begin
                state_q <= eb_pkg::EB_IDLE;
              end
            endcase
          end
        end
        eb_pkg::EB_ACK: begin
          if (ev.fall) begin
            if (phase_q == eb_pkg::EB_PH_READ) begin
              shift_q   <= rd_byte;
              drive_n_q <= rd_byte[7];
              state_q   <= eb_pkg::EB_TX;
            end else begin
              drive_n_q <= 1'h1;
              state_q   <= eb_pkg::EB_RX;
            end
          end
        end
        eb_pkg::EB_TX: begin
          if (ev.rise) begin
            cnt_q <= cnt_q + 4'h1;
          end else if (byte_done) begin
            cnt_q     <= 4'h0;
            drive_n_q <= 1'h1;
            addr_q    <= addr_q + 7'h01;
            state_q   <= eb_pkg::EB_RACK;
          end else if (ev.fall) begin
            shift_q   <= {shift_q[6:0], 1'h0};
            drive_n_q <= shift_q[6];
          end
        end
        eb_pkg::EB_RACK: begin
          if (ev.rise) begin
            master_ack_q <= ~bit_s_q[1];
          end else if (ev.fall) begin
            if (master_ack_q) begin
              shift_q   <= rd_byte;
              drive_n_q <= rd_byte[7];
              state_q   <= eb_pkg::EB_TX;
            end else begin
              state_q <= eb_pkg::EB_IDLE;
            end
          end
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // self-timed write cycle
  // --------------------------------------------------------------------------
  logic [31:0] busy_cnt_q;
  assign commit_now = busy_q && (busy_cnt_q == (WR_CYCLES - 32'h1));
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      busy_q     <= 1'h0;
      busy_cnt_q <= 32'h0;
    end else if (stop_commit) begin
      busy_q     <= 1'h1;
      busy_cnt_q <= 32'h0;
    end else if (busy_q) begin
      if (wp_s || low_s || commit_now) begin
        busy_q <= 1'h0;
      end
      busy_cnt_q <= busy_cnt_q + 32'h1;
    end
  end
  always_ff @(posedge ref_clk_in) begin
    if (commit_now && !wp_s && !low_s) begin
      for (int i = 0; i < `EB_PAGE_BYTES; i++) begin
        if (pg_valid_q[i]) begin
          mem[{pg_page_q, i[2:0]}] <= pg_buf_q[i];
        end
      end
    end
  end
  always_ff @(posedge ref_clk_in) begin
    if ((state_q == eb_pkg::EB_RX) && byte_done && (phase_q == eb_pkg::EB_PH_WDATA)) begin
      pg_buf_q[pg_idx_q] <= shift_q;
    end
  end
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      write_busy_out <= 1'h0;
    end else begin
      write_busy_out <= busy_q;
    end
  end
endmodule

// ---- pkg/eb_regs.svh ----
`ifndef EB_REGS_SVH
`define EB_REGS_SVH

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define EB_REF_CLK_HZ        20000000
`define EB_WR_TIME_MS        5
`define EB_WR_CYCLES         ((`EB_WR_TIME_MS * `EB_REF_CLK_HZ) / 1000)

// ----------------------------------------------------------------------------
// array and slave address layout
// ----------------------------------------------------------------------------
`define EB_MEM_DEPTH         128
`define EB_PAGE_BYTES        8
`define EB_BITS_PER_BYTE     4'h8
`define EB_SA_TYPE_MSB       7
`define EB_SA_TYPE_LSB       4
`define EB_SA_SEL_MSB        3
`define EB_SA_SEL_LSB        1
`define EB_SA_RW_BIT         0

`endif

// ---- pkg/eb_pkg.sv ----
package eb_pkg;

  // --------------------------------------------------------------------------
  // bus events passed from the link domain as toggles
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic rise;
    logic fall;
    logic start;
    logic stop;
  } eb_evt_t;

  // --------------------------------------------------------------------------
  // protocol engine
  // --------------------------------------------------------------------------
  typedef enum logic [4:0] {
    EB_IDLE = 5'b00001,
    EB_RX   = 5'b00010,
    EB_ACK  = 5'b00100,
    EB_TX   = 5'b01000,
    EB_RACK = 5'b10000
  } eb_state_t;

  typedef enum logic [3:0] {
    EB_PH_ADDR  = 4'b0001,
    EB_PH_WADDR = 4'b0010,
    EB_PH_WDATA = 4'b0100,
    EB_PH_READ  = 4'b1000
  } eb_phase_t;

endpackage

// ---- verif/eb_chk.sv ----
`timescale 1ns/100ps
module eb_chk #(
  parameter int unsigned WR_CYCLES = 50
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic link_clk_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic write_inhibit_in,
  input wire logic low_supply_write_lockout_in,
  input wire logic sda_oe_n_out,
  input wire logic write_busy_out
);
  // ----
  // bus conditions seen at the engine clock
  // ----
  logic        sda_p_q;
  logic        scl_p_q;
  logic        rise_q;
  logic [7:0]  since_q;
  int unsigned cnt_q;
  logic        stop_w;
  logic        start_w;
  assign stop_w  = scl_in & scl_p_q & sda_in & ~sda_p_q;
  assign start_w = scl_in & scl_p_q & ~sda_in & sda_p_q;
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sda_p_q <= 1'b1;
      scl_p_q <= 1'b1;
      rise_q  <= 1'b1;
      since_q <= 8'hff;
      cnt_q   <= 0;
    end else begin
      sda_p_q <= sda_in;
      scl_p_q <= scl_in;
      rise_q  <= start_w ? 1'b0 : (rise_q | (scl_in & ~scl_p_q));
      since_q <= stop_w ? 8'h00 : ((since_q == 8'hff) ? since_q : since_q + 8'h01);
      cnt_q   <= write_busy_out ? cnt_q + 1 : 0;
    end
  end
  // ----
  // assertions
  // ----
  busy_quiet_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    write_busy_out |-> sda_oe_n_out) else $error("ack driven while busy");
  busy_bound_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    write_busy_out |-> cnt_q <= WR_CYCLES) else $error("write cycle too long");
  busy_cause_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    $rose(write_busy_out) |-> since_q < 8'h20) else $error("busy without stop");
  lockout_block_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    low_supply_write_lockout_in [*8] |-> !write_busy_out) else $error("write in lockout");
  inhibit_block_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    write_inhibit_in [*8] |-> !write_busy_out) else $error("write while inhibited");
  reset_idle_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    $rose(rst_n_in) |-> (sda_oe_n_out && !write_busy_out) [*4]) else $error("not standby");
  cancel_quiet_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    stop_w && !rise_q && !write_busy_out |=> !write_busy_out [*8]) else $error("cancel wrote");
  bit_stable_a: assert property (@(posedge link_clk_in) disable iff (!rst_n_in)
    scl_in && $past(scl_in) |-> $stable(sda_oe_n_out)) else $error("data moved, clock high");
  cover property (@(posedge ref_clk_in) disable iff (!rst_n_in) $rose(write_busy_out));
  cover property (@(posedge ref_clk_in) disable iff (!rst_n_in) stop_w && !rise_q);
  cover property (@(posedge ref_clk_in) disable iff (!rst_n_in) $fell(sda_oe_n_out));
endmodule

bind eb_eeprom_slave eb_chk #(.WR_CYCLES(WR_CYCLES)) i_chk (
  .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .link_clk_in(link_clk_in),
  .scl_in(scl_in), .sda_in(sda_in), .write_inhibit_in(write_inhibit_in),
  .low_supply_write_lockout_in(low_supply_write_lockout_in),
  .sda_oe_n_out(sda_oe_n_out), .write_busy_out(write_busy_out));

// ---- verif/eb_bus_master.sv ----
`timescale 1ns/100ps
module eb_bus_master #(
  parameter int HALF = 25
) (
  input  wire logic clk_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_out
);
  // ----
  // open-drain master, clock parked high between frames
  // ----
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  task automatic hp();
    repeat (HALF) @(posedge clk_in);
  endtask
  task automatic start_hi();
    @(posedge clk_in);
    sda_out <= 1'b1;
    hp();
    scl_out <= 1'b1;
    hp();
    sda_out <= 1'b0;
    hp();
  endtask
  task automatic start();
    start_hi();
    scl_out <= 1'b0;
  endtask
  // nine starts in a row, clock pulsed low between them
  task automatic sw_reset();
    for (int i = 0; i < 9; i++) begin
      start();
    end
  endtask
  task automatic cancel();
    start_hi();
    sda_out <= 1'b1;
    hp();
  endtask
  task automatic stop();
    @(posedge clk_in);
    sda_out <= 1'b0;
    hp();
    scl_out <= 1'b1;
    hp();
    sda_out <= 1'b1;
    hp();
  endtask
  task automatic bit_io(input logic v, output logic r);
    @(posedge clk_in);
    sda_out <= v;
    hp();
    scl_out <= 1'b1;
    hp();
    r = sda_in;
    scl_out <= 1'b0;
  endtask
  task automatic xfer(input logic [7:0] b, input logic mack, output logic [7:0] rd,
                      output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], rd[i]);
    end
    bit_io(mack, r);
    ack = ~r;
  endtask
endmodule

// ---- verif/eb_eeprom_slave_test.sv ----
`timescale 1ns/100ps
module eb_eeprom_slave_test;
  localparam int unsigned WR_CYC = 2000;
  localparam logic [3:0]  DEV_T  = 4'h9; // arbitrary device type value
  localparam logic [2:0]  SEL    = 3'h5;
  logic       clk             = 1'b0;
  logic       lclk            = 1'b0;
  logic       rst_n           = 1'b0;
  logic [2:0] sel             = SEL;
  logic       wp              = 1'b0;
  logic       lv              = 1'b0;
  logic       m_scl;
  logic       m_sda;
  logic       d_sda;
  logic       d_oe_n;
  logic       busy;
  wire        sda_w           = m_sda & (d_oe_n | d_sda);
  logic [7:0] rd;
  logic       ak;
  int         mismatches      = 0;
  int         samples_checked = 0;
  int         cyc             = 0;
  always #25 clk = ~clk;
  initial begin
    #3.3;
    forever #7.5 lclk = ~lclk;
  end
  eb_eeprom_slave #(.WR_CYCLES(WR_CYC), .DEV_TYPE(DEV_T)) i_dut (
    .ref_clk_in(clk), .rst_n_in(rst_n), .link_clk_in(lclk), .scl_in(m_scl),
    .sda_in(sda_w), .select_pin_0_in(sel[0]), .select_pin_1_in(sel[1]),
    .select_pin_2_in(sel[2]), .write_inhibit_in(wp), .low_supply_write_lockout_in(lv),
    .sda_out(d_sda), .sda_oe_n_out(d_oe_n), .write_busy_out(busy));
  eb_bus_master i_m (.clk_in(clk), .sda_in(sda_w), .scl_out(m_scl), .sda_out(m_sda));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic adr(input logic [2:0] s, input logic rw);
    i_m.start();
    i_m.xfer({DEV_T, s, rw}, 1'b1, rd, ak);
  endtask
  task automatic wr(input logic [7:0] wa, input logic [7:0] dt);
    adr(SEL, 1'b0);
    chk({7'h0, ak}, 8'h01);
    i_m.xfer(wa, 1'b1, rd, ak);
    i_m.xfer(dt, 1'b1, rd, ak);
    i_m.stop();
  endtask
  task automatic rrd(input logic [7:0] wa);
    adr(SEL, 1'b0);
    i_m.xfer(wa, 1'b1, rd, ak);
    adr(SEL, 1'b1);
    i_m.xfer(8'hff, 1'b1, rd, ak);
    i_m.stop();
  endtask
  task automatic t_poll();
    int n;
    n = 0;
    wr(8'h20, 8'h5a);
    chk({7'h0, busy}, 8'h01);
    ak = 1'b0;
    while (!ak && n < 20) begin
      adr(SEL, 1'b1);
      if (!ak) i_m.stop();
      n++;
    end
    chk({7'h0, n > 1}, 8'h01);
    chk({7'h0, busy}, 8'h00);
    i_m.xfer(8'hff, 1'b1, rd, ak);
    i_m.stop();
    chk(rd, 8'h5a);
  endtask
  task automatic t_select();
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      sel <= 3'(i);
      repeat (4) @(posedge clk);
      adr(SEL, 1'b0);
      chk({7'h0, ak}, {7'h0, 3'(i) == SEL});
      i_m.stop();
    end
    @(posedge clk);
    sel <= SEL;
  endtask
  task automatic t_cancel();
    adr(SEL, 1'b0);
    i_m.xfer(8'h20, 1'b1, rd, ak);
    i_m.xfer(8'h3c, 1'b1, rd, ak);
    i_m.cancel();
    repeat (20) @(posedge clk);
    chk({7'h0, busy}, 8'h00);
    rrd(8'h20);
    chk(rd, 8'h5a);
  endtask
  task automatic t_block();
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      wp <= k[0];
      lv <= !k[0];
      wr(8'h20, 8'hc3);
      repeat (20) @(posedge clk);
      chk({7'h0, busy}, 8'h00);
      wp <= 1'b0;
      lv <= 1'b0;
      rrd(8'h20);
      chk(rd, 8'h5a);
    end
  endtask
  task automatic t_reset();
    wr(8'h40, 8'h11);
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk({7'h0, busy}, 8'h00);
    adr(SEL, 1'b0);
    chk({7'h0, ak}, 8'h01);
    i_m.stop();
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      mismatches++;
      complete_run();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (10) @(posedge clk);
    i_m.sw_reset();
    t_poll();
    t_select();
    t_cancel();
    t_block();
    t_reset();
    complete_run();
  end
endmodule
